/* File: design/e3aes_top.sv */
// Receive alarm detection and information register of the E3 alarm and event status block
`timescale 1ns/1ps
`include "e3aes_cfg.svh"

module e3aes_top (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    input  wire e3aes_pkg::e3aes_rx_type  rx,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    output e3aes_pkg::e3aes_alarm_type    alarm
);
    import e3aes_pkg::*;

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  zrun;
        logic        los;
        logic        los_win;
        logic [7:0]  win_cnt;
        logic [10:0] fbit_cnt;
        logic [2:0]  zcur;
        logic [2:0]  zprev;
        logic        ais;
        logic [2:0]  fas_bad;
        logic [1:0]  fas_good;
        logic        lof;
        logic [15:0] f_hist;
        logic [15:0] m_hist;
        logic [2:0]  r_act;
        logic [2:0]  r_inact;
        logic        rai;
        logic        synced;
        logic [7:0]  align;
        logic        sn;
        logic [9:0]  aid_win;
        logic [10:0] aid_ones;
        logic        aid;
        logic [15:0] flags;
    } e3aes_state_type;

    e3aes_state_type s_reg;
    e3aes_state_type s_next;
    e3aes_ctrl_type  ctrl;
    logic            rd_clr;
    logic [15:0]     info;
    logic [15:0]     ev;
    logic            excess_zeros_flag;
    logic [7:0]      exz_thr;
    logic            rzero;
    logic [2:0]      zcur_inc;
    logic [3:0]      ztotal;
    logic            r_strobe;
    logic            r_act_bit;
    logic            r_inact_bit;
    logic [10:0]     ones_inc;

    e3aes_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .info      (info),
        .alarm     (alarm),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .ctrl      (ctrl),
        .rd_clr    (rd_clr)
    );

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    assign rzero = rx.bit_valid & ~rx.bit_data;
    assign exz_thr = ctrl.e3_mode ? `E3AES_EXZ_E3 : `E3AES_EXZ_T3;
    // Fires once per zero string, at the zero that reaches the threshold
    assign excess_zeros_flag = rzero & ((s_reg.zrun + 8'h01) == exz_thr);
    assign zcur_inc = (rzero && (s_reg.zcur != `E3AES_AIS_SAT)) ? s_reg.zcur + 3'h1
                                                                  : s_reg.zcur;
    assign ztotal = {1'b0, s_reg.zprev} + {1'b0, zcur_inc};
    assign r_strobe = ctrl.e3_mode ? rx.frame_start : rx.x_valid;
    assign r_act_bit = ctrl.e3_mode ? rx.rai_bit : (~rx.x1 & ~rx.x2);
    assign r_inact_bit = ctrl.e3_mode ? ~rx.rai_bit : (rx.x1 & rx.x2);
    assign ones_inc = s_reg.aid_ones + {10'h000, rx.cbit1};

    always_comb begin
        s_next = s_reg;
        ev = 16'h0000;
        ev[`E3AES_B_ZSUB] = rx.codeword;
        ev[`E3AES_B_EXZ] = excess_zeros_flag;

        if (rx.bit_valid) begin
            if (rx.bit_data) begin
                s_next.zrun = 8'h00;
            end else if (s_reg.zrun != `E3AES_LOS_ZEROS) begin
                s_next.zrun = s_reg.zrun + 8'h01;
            end
        end

        // Loss of signal: meaningless on a unipolar line, so it is held off
        if (ctrl.unipolar) begin
            s_next.los = 1'b0;
            s_next.los_win = 1'b0;
        end else if (!s_reg.los) begin
            s_next.los_win = 1'b0;
            if (rzero && ((s_reg.zrun + 8'h01) == `E3AES_LOS_ZEROS)) begin
                s_next.los = 1'b1;
            end
        end else if (rx.bit_valid) begin
            if (!s_reg.los_win) begin
                if (rx.bit_data) begin
                    s_next.los_win = 1'b1;
                    s_next.win_cnt = 8'h01;
                end
            end else if (excess_zeros_flag) begin
                // Window spoilt; the next one restarts at the next received one
                s_next.los_win = 1'b0;
            end else if (s_reg.win_cnt == `E3AES_LOS_LAST) begin
                s_next.los = 1'b0;
                s_next.los_win = 1'b0;
                ev[`E3AES_B_LOS_CLR] = 1'b1;
            end else begin
                s_next.win_cnt = s_reg.win_cnt + 8'h01;
            end
        end

        // Unframed all-ones detection over two 1536-bit frames
        if (!ctrl.e3_mode) begin
            s_next.ais = 1'b0;
            s_next.fbit_cnt = 11'h000;
            s_next.zcur = 3'h0;
            s_next.zprev = 3'h0;
        end else if (rx.bit_valid) begin
            if (s_reg.fbit_cnt == `E3AES_FRAME_LAST) begin
                s_next.fbit_cnt = 11'h000;
                s_next.zprev = zcur_inc;
                s_next.zcur = 3'h0;
                s_next.ais = (ztotal <= `E3AES_AIS_MAXZ);
                if (s_reg.ais && (ztotal > `E3AES_AIS_MAXZ)) begin
                    ev[`E3AES_B_AIS_CLR] = 1'b1;
                end
            end else begin
                s_next.fbit_cnt = s_reg.fbit_cnt + 11'h001;
                s_next.zcur = zcur_inc;
            end
        end

        // Frame loss and framing errors
        if (ctrl.e3_mode) begin
            if (rx.fas_valid && rx.fas_ok) begin
                s_next.fas_bad = 3'h0;
                if (s_reg.fas_good != `E3AES_FAS_GOOD) begin
                    s_next.fas_good = s_reg.fas_good + 2'h1;
                end
                if (s_reg.lof && ((s_reg.fas_good + 2'h1) == `E3AES_FAS_GOOD)) begin
                    s_next.lof = 1'b0;
                    ev[`E3AES_B_LOF_CLR] = 1'b1;
                end
            end else if (rx.fas_valid) begin
                s_next.fas_good = 2'h0;
                ev[`E3AES_B_FERR] = 1'b1;
                if (s_reg.fas_bad != `E3AES_FAS_BAD) begin
                    s_next.fas_bad = s_reg.fas_bad + 3'h1;
                end
                if ((s_reg.fas_bad + 3'h1) == `E3AES_FAS_BAD) begin
                    s_next.lof = 1'b1;
                    ev[`E3AES_B_SEVF] = 1'b1;
                end
            end
        end else begin
            if (rx.fbit_valid) begin
                s_next.f_hist = {s_reg.f_hist[14:0], rx.fbit_err};
                ev[`E3AES_B_FERR] = rx.fbit_err;
                if (e3aes_ones16(s_next.f_hist) >= `E3AES_F_ERRS) begin
                    s_next.lof = 1'b1;
                    ev[`E3AES_B_SEVF] = rx.fbit_err;
                end
            end
            if (rx.mbit_valid) begin
                s_next.m_hist = {12'h000, s_reg.m_hist[2:0], rx.mbit_err};
                ev[`E3AES_B_MERR] = rx.mbit_err;
                if (e3aes_ones16(s_next.m_hist) >= `E3AES_M_ERRS) begin
                    s_next.lof = 1'b1;
                end
            end
            if (rx.sync_acq && s_reg.lof) begin
                s_next.lof = 1'b0;
                s_next.f_hist = 16'h0000;
                s_next.m_hist = 16'h0000;
                ev[`E3AES_B_LOF_CLR] = 1'b1;
            end
        end

        // Realignment: only meaningful once a first alignment is known
        if (rx.sync_acq) begin
            s_next.synced = 1'b1;
            s_next.align = rx.align;
            ev[`E3AES_B_REALIGNMENT_FLAG] = s_reg.synced & (rx.align != s_reg.align);
        end

        // Remote alarm, bit 11 per E3 frame or X1 X2 per T3 M frame
        if (r_strobe) begin
            s_next.r_act = 3'h0;
            s_next.r_inact = 3'h0;
            if (r_act_bit) begin
                s_next.r_act = (s_reg.r_act == `E3AES_RAI_FRAMES) ? s_reg.r_act
                                                                  : s_reg.r_act + 3'h1;
                if ((s_reg.r_act + 3'h1) == `E3AES_RAI_FRAMES) begin
                    s_next.rai = 1'b1;
                end
            end else if (r_inact_bit) begin
                s_next.r_inact = (s_reg.r_inact == `E3AES_RAI_FRAMES) ? s_reg.r_inact
                                                                      : s_reg.r_inact + 3'h1;
                if (s_reg.rai && ((s_reg.r_inact + 3'h1) == `E3AES_RAI_FRAMES)) begin
                    s_next.rai = 1'b0;
                    ev[`E3AES_B_RAI_CLR] = 1'b1;
                end
            end
        end

        if (ctrl.e3_mode && rx.frame_start) begin
            s_next.sn = rx.sn_bit;
        end

        // Application ID over windows of 1024 M frames
        if (!ctrl.e3_mode && rx.cbit_valid) begin
            if (s_reg.aid_win == `E3AES_AID_LAST) begin
                s_next.aid = (ones_inc >= `E3AES_AID_ONES);
                s_next.aid_win = 10'h000;
                s_next.aid_ones = 11'h000;
            end else begin
                s_next.aid_win = s_reg.aid_win + 10'h001;
                s_next.aid_ones = ones_inc;
            end
        end

        // Set wins over the clearing read
        s_next.flags = ((s_reg.flags & ~{16{rd_clr}}) | ev) & `E3AES_FLAG_MASK;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    // Polled register only; no interrupt path leaves this block
    always_comb begin
        info = s_reg.flags;
        info[`E3AES_B_NAT] = s_reg.sn;
        info[`E3AES_B_AID] = s_reg.aid;
    end

    assign alarm = '{rai: s_reg.rai, ais: s_reg.ais, lof: s_reg.lof, los: s_reg.los};

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_los_set;
        !ctrl.unipolar && !s_reg.los && rzero && (s_reg.zrun == `E3AES_LOS_LAST)
            |=> s_reg.los;
    endproperty
    a_los_set: assert property (p_los_set) else $error("LOS not set after 192 zeros");

    property p_unipolar;
        ctrl.unipolar |=> !s_reg.los;
    endproperty
    a_unipolar: assert property (p_unipolar) else $error("LOS seen in unipolar mode");

    property p_lof_set;
        ctrl.e3_mode && rx.fas_valid && !rx.fas_ok && (s_reg.fas_bad == 3'h3)
            |=> s_reg.lof && s_reg.flags[`E3AES_B_SEVF];
    endproperty
    a_lof_set: assert property (p_lof_set) else $error("LOF or SEF missed");

    property p_lof_clr;
        ctrl.e3_mode && s_reg.lof && rx.fas_valid && rx.fas_ok && (s_reg.fas_good == 2'h2)
            |=> !s_reg.lof && s_reg.flags[`E3AES_B_LOF_CLR];
    endproperty
    a_lof_clr: assert property (p_lof_clr) else $error("LOF exit missed");

    property p_rai_set;
        ctrl.e3_mode && rx.frame_start && rx.rai_bit && (s_reg.r_act == 3'h3) |=> s_reg.rai;
    endproperty
    a_rai_set: assert property (p_rai_set) else $error("RAI not set");

    property p_exz;
        excess_zeros_flag |=> s_reg.flags[`E3AES_B_EXZ];
    endproperty
    a_exz: assert property (p_exz) else $error("Excess zero flag missed");

    property p_set_wins;
        rd_clr && rx.codeword |=> s_reg.flags[`E3AES_B_ZSUB];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event lost to read clear");

    property p_rd_clear;
        rd_clr && !rx.codeword |=> !s_reg.flags[`E3AES_B_ZSUB];
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("Flag not cleared by read");

    property p_sn;
        ctrl.e3_mode && rx.frame_start |=> s_reg.sn == $past(rx.sn_bit);
    endproperty
    a_sn: assert property (p_sn) else $error("National bit not loaded");

    property p_los_exit;
        $fell(s_reg.los) && !$past(ctrl.unipolar) |-> s_reg.flags[`E3AES_B_LOS_CLR];
    endproperty
    a_los_exit: assert property (p_los_exit) else $error("LOS exit not flagged");

    c_los: cover property ($rose(s_reg.los));
    c_lof_exit: cover property ($fell(s_reg.lof));
    c_rai: cover property ($rose(s_reg.rai));
    c_realignment_flag: cover property ($rose(s_reg.flags[`E3AES_B_REALIGNMENT_FLAG]));

endmodule : e3aes_top

/* File: design/e3aes_cfg.svh */
// Constants of the E3 alarm and event status block: offsets, bit positions, counts
`ifndef E3AES_CFG_SVH
`define E3AES_CFG_SVH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define E3AES_A_INFO      8'h00
`define E3AES_A_CTRL      8'h04
`define E3AES_A_ALARM     8'h08
`define E3AES_CTRL_RESET  2'h0
`define E3AES_FLAG_MASK   16'h3cff

// ---------------------------------------------------------------------------
// Bit positions of the information register
// ---------------------------------------------------------------------------
`define E3AES_B_REALIGNMENT_FLAG      0
`define E3AES_B_ZSUB      1
`define E3AES_B_FERR      2
`define E3AES_B_MERR      3
`define E3AES_B_EXZ       4
`define E3AES_B_SEVF      5
`define E3AES_B_NAT       8
`define E3AES_B_AID       9
`define E3AES_B_LOS_CLR   10
`define E3AES_B_LOF_CLR   11
`define E3AES_B_AIS_CLR   12
`define E3AES_B_RAI_CLR   13

// ---------------------------------------------------------------------------
// Counts
// ---------------------------------------------------------------------------
`define E3AES_LOS_ZEROS   8'd192
`define E3AES_LOS_LAST    8'd191
`define E3AES_EXZ_T3      8'd3
`define E3AES_EXZ_E3      8'd4
`define E3AES_FRAME_LAST  11'd1535
`define E3AES_AIS_MAXZ    4'd4
`define E3AES_AIS_SAT     3'd5
`define E3AES_FAS_BAD     3'd4
`define E3AES_FAS_GOOD    2'd3
`define E3AES_RAI_FRAMES  3'd4
`define E3AES_F_ERRS      5'd3
`define E3AES_M_ERRS      5'd2
`define E3AES_AID_LAST    10'd1023
`define E3AES_AID_ONES    11'd1020

`endif

/* File: design/e3aes_pkg.sv */
// Types shared by the E3 alarm and event status block
package e3aes_pkg;

    // Receive events from the framer datapath, all on hclk
    typedef struct packed {
        logic       bit_valid;
        logic       bit_data;
        logic       codeword;
        logic       frame_start;
        logic       rai_bit;
        logic       sn_bit;
        logic       fas_valid;
        logic       fas_ok;
        logic       fbit_valid;
        logic       fbit_err;
        logic       mbit_valid;
        logic       mbit_err;
        logic       x_valid;
        logic       x1;
        logic       x2;
        logic       cbit_valid;
        logic       cbit1;
        logic       sync_acq;
        logic [7:0] align;
    } e3aes_rx_type;

    typedef struct packed {
        logic unipolar;
        logic e3_mode;
    } e3aes_ctrl_type;

    typedef struct packed {
        logic rai;
        logic ais;
        logic lof;
        logic los;
    } e3aes_alarm_type;

    function automatic logic [4:0] e3aes_ones16(input logic [15:0] v);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 16; i++) begin
            c = c + {4'h0, v[i]};
        end
        return c;
    endfunction : e3aes_ones16

endpackage : e3aes_pkg

/* File: design/e3aes_ahb_slave.sv */
// AHB-Lite register slave of the E3 alarm and event status block
`timescale 1ns/1ps
`include "e3aes_cfg.svh"

module e3aes_ahb_slave (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    input  wire logic [15:0]              info,
    input  wire e3aes_pkg::e3aes_alarm_type alarm,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    output e3aes_pkg::e3aes_ctrl_type     ctrl,
    output logic                          rd_clr
);
    import e3aes_pkg::*;

    typedef struct packed {
        logic           wr_pend;
        logic [7:0]     wr_addr;
        e3aes_ctrl_type ctrl;
        logic [31:0]    rdata;
        logic           ready;
        logic           resp;
    } e3aes_slv_type;

    e3aes_slv_type s_reg;
    e3aes_slv_type s_next;
    logic          take;

    // Read data is captured at the address-phase edge, so no wait state is needed
    assign take = hsel & htrans[1] & hready;
    assign rd_clr = take & ~hwrite & (haddr[7:0] == `E3AES_A_INFO);

    always_comb begin
        s_next = s_reg;
        s_next.ready = 1'b1;
        s_next.resp = 1'b0;
        if (s_reg.wr_pend && (s_reg.wr_addr == `E3AES_A_CTRL)) begin
            s_next.ctrl = e3aes_ctrl_type'(hwdata[1:0]);
        end
        s_next.wr_pend = take & hwrite;
        s_next.wr_addr = haddr[7:0];
        if (take && !hwrite) begin
            case (haddr[7:0])
                `E3AES_A_INFO:  s_next.rdata = {16'h0000, info};
                `E3AES_A_CTRL:  s_next.rdata = {30'h0, s_reg.ctrl};
                `E3AES_A_ALARM: s_next.rdata = {28'h0, alarm};
                default:        s_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '{wr_pend: 1'b0, wr_addr: 8'h00, ctrl: `E3AES_CTRL_RESET,
                       rdata: 32'h0, ready: 1'b1, resp: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign hrdata = s_reg.rdata;
    assign hreadyout = s_reg.ready;
    assign hresp = s_reg.resp;
    assign ctrl = s_reg.ctrl;

endmodule : e3aes_ahb_slave

/* File: test/e3aes_rx_model.sv */
// Receive framer datapath model that feeds events to the alarm block
`timescale 1ns/1ps

module e3aes_rx_model (
    input  wire logic               hclk,
    output e3aes_pkg::e3aes_rx_type rx
);
    import e3aes_pkg::*;

    initial rx = '0;

    // Idle cycles flip the data line so a stale bit never looks valid
    task automatic idle();
        e3aes_rx_type t;
        t = '0;
        t.bit_data = ~rx.bit_data;
        @(posedge hclk);
        rx <= t;
    endtask : idle

    task automatic put(input e3aes_rx_type v);
        @(posedge hclk);
        rx <= v;
        idle();
    endtask : put

    task automatic bits(input int n, input logic v);
        e3aes_rx_type t;
        t = '0;
        t.bit_valid = 1'b1;
        t.bit_data = v;
        repeat (n) begin
            @(posedge hclk);
            rx <= t;
        end
        idle();
    endtask : bits
endmodule : e3aes_rx_model

/* File: test/e3_alarm_event_status_test.sv */
// Self-checking bench of the E3 alarm and event status block
`timescale 1ns/1ps

module e3_alarm_event_status_test;
    import e3aes_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h1c4ac8ce;
    logic [1:0] htrans = 2'h0;
    e3aes_rx_type rx;
    e3aes_alarm_type alarm;
    int fails = 0, num_checks = 0;

    always #2.5 hclk = ~hclk;

    e3aes_top e3aes_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .rx(rx), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm(alarm));
    e3aes_rx_model e3aes_rx_model_inst (.hclk(hclk), .rx(rx));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Application ID status expected after one window holding this many ones
    function automatic logic aid_of(input int ones);
        return ones >= 1020;
    endfunction : aid_of

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Bounded wait for an edge at which the slave is ready
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc

    // Alarms are looked at mid-cycle, once the last event edge has landed
    task automatic alm(input logic [3:0] e);
        @(negedge hclk);
        chk({28'h0, alarm}, {28'h0, e});
        @(posedge hclk);
    endtask : alm

    initial begin
        #100000;
        fails++;
        conclude();
    end

    initial begin
        e3aes_rx_type t;
        int z;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(8'h00, 32'h0); rdc(8'h04, 32'h0); rdc(8'h08, 32'h0); rdc(8'h0c, 32'h0);
        ahb(1'b1, 8'h00, 32'hffff);
        rdc(8'h00, 32'h0);
        ahb(1'b1, 8'h04, 32'h1);
        rdc(8'h04, 32'h1);
        $display("reset and map done");
        e3aes_rx_model_inst.bits(191, 1'b0);
        alm(4'h0);
        e3aes_rx_model_inst.bits(1, 1'b0);
        alm(4'h1);
        e3aes_rx_model_inst.bits(192, 1'b1);
        alm(4'h0);
        rdc(8'h00, 32'h0410);
        rdc(8'h00, 32'h0);
        e3aes_rx_model_inst.bits(4224, 1'b1);
        alm(4'h4);
        repeat (5) begin
            e3aes_rx_model_inst.bits(1, 1'b0);
            e3aes_rx_model_inst.bits(1, 1'b1);
        end
        e3aes_rx_model_inst.bits(1526, 1'b1);
        alm(4'h0);
        rdc(8'h00, 32'h1000);
        $display("loss of signal and AIS done");
        t = '0;
        t.fas_valid = 1'b1;
        repeat (4) e3aes_rx_model_inst.put(t);
        alm(4'h2);
        t.fas_ok = 1'b1;
        repeat (3) e3aes_rx_model_inst.put(t);
        alm(4'h0);
        rdc(8'h00, 32'h0824);
        t = '0;
        t.frame_start = 1'b1;
        t.rai_bit = 1'b1;
        t.sn_bit = 1'b1;
        repeat (3) e3aes_rx_model_inst.put(t);
        alm(4'h0);
        e3aes_rx_model_inst.put(t);
        alm(4'h8);
        rdc(8'h00, 32'h0100);
        t.rai_bit = 1'b0;
        t.sn_bit = 1'b0;
        repeat (4) e3aes_rx_model_inst.put(t);
        alm(4'h0);
        rdc(8'h00, 32'h2000);
        $display("frame loss and remote alarm done");
        seed = xs(seed);
        t = '0;
        t.sync_acq = 1'b1;
        t.align = seed[7:0];
        e3aes_rx_model_inst.put(t);
        rdc(8'h00, 32'h0);
        t.align = ~seed[7:0];
        e3aes_rx_model_inst.put(t);
        rdc(8'h00, 32'h1);
        t = '0;
        t.codeword = 1'b1;
        e3aes_rx_model_inst.put(t);
        rdc(8'h00, 32'h2);
        rdc(8'h00, 32'h0);
        // A code word lands at the very edge of a clearing read
        fork
            e3aes_rx_model_inst.put(t);
            begin
                @(posedge hclk);
                rdc(8'h00, 32'h0);
            end
        join
        rdc(8'h00, 32'h2);
        rdc(8'h00, 32'h0);
        $display("realignment and code words done");
        ahb(1'b1, 8'h04, 32'h0);
        t = '0;
        t.cbit_valid = 1'b1;
        t.cbit1 = 1'b1;
        repeat (1020) e3aes_rx_model_inst.put(t);
        t.cbit1 = 1'b0;
        repeat (4) e3aes_rx_model_inst.put(t);
        t = '0;
        t.fbit_valid = 1'b1;
        t.fbit_err = 1'b1;
        repeat (3) e3aes_rx_model_inst.put(t);
        t = '0;
        t.mbit_valid = 1'b1;
        t.mbit_err = 1'b1;
        e3aes_rx_model_inst.put(t);
        alm(4'h2);
        rdc(8'h00, 32'h022c);
        // A random count of zero C bits, always enough to drop the status
        seed = xs(seed);
        z = 5 + seed[1:0];
        t = '0;
        t.cbit_valid = 1'b1;
        for (int i = 0; i < 1024; i++) begin
            t.cbit1 = (i >= z);
            e3aes_rx_model_inst.put(t);
        end
        rdc(8'h00, {22'h0, aid_of(1024 - z), 9'h0});
        t = '0;
        t.x_valid = 1'b1;
        repeat (4) e3aes_rx_model_inst.put(t);
        alm(4'ha);
        rdc(8'h08, 32'ha);
        t.x1 = 1'b1;
        t.x2 = 1'b1;
        repeat (4) e3aes_rx_model_inst.put(t);
        alm(4'h2);
        rdc(8'h00, 32'h2000 | {22'h0, aid_of(1024 - z), 9'h0});
        $display("T3 mode done");
        ahb(1'b1, 8'h04, 32'h3);
        repeat (64) begin
            seed = xs(seed);
            e3aes_rx_model_inst.bits(1, seed[0]);
        end
        e3aes_rx_model_inst.bits(200, 1'b0);
        @(negedge hclk);
        chk({31'h0, alarm.los}, 32'h0);
        @(posedge hclk);
        $display("unipolar done");
        conclude();
    end
endmodule : e3_alarm_event_status_test
